// ### logic/psr_regs.vh
`ifndef PSR_REGS_VH
`define PSR_REGS_VH
// register byte offsets on the apb slave
`define PSR_OFF_PB_DATA 12'h000
`define PSR_OFF_PB_ADDR 12'h004
`define PSR_OFF_SPY_DATA 12'h008
`define PSR_OFF_SPY_ADDR 12'h00c
`define PSR_OFF_STATUS 12'h010
`define PSR_OFF_CTRL 12'h014
`define PSR_OFF_RING 12'h018
`define PSR_OFF_PORT 12'h01c
`define PSR_OFF_FLASH 12'h020
`define PSR_OFF_GEO 12'h024
// buffer geometry
`define PSR_DEPTH 256
`define PSR_AW 8
`define PSR_DW 16
// ring word layout: valid, 5-bit select, write, 4-bit data
`define PSR_RING_W 11
`define PSR_SEL_W 5
// broadcast command that starts playback and capture
`define PSR_CMD_START 8'h01
`define PSR_CMD_BCR 8'h02
// ctrl bits
`define PSR_CTRL_SERIAL 0
`define PSR_CTRL_SPY_IN 1
`define PSR_ZERO32 32'h00000000
`endif

// ### logic/psr_buf.v
`timescale 1ns/1ns
`default_nettype none
`include "psr_regs.vh"
// 256x16 flop memory with auto-incrementing host pointer and sequential stream side
module psr_buf #(
	parameter AW = `PSR_AW,
	parameter DW = `PSR_DW
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// host side
	input wire ptr_load,
	input wire [AW-1:0] ptr_val,
	input wire host_wr,
	input wire host_rd_adv,
	input wire [DW-1:0] host_wdata,
	output wire [AW-1:0] ptr,
	output wire [DW-1:0] host_rdata,
	// stream side
	input wire strm_we,
	input wire [AW-1:0] strm_addr,
	input wire [DW-1:0] strm_wdata,
	output wire [DW-1:0] strm_rdata
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	reg [AW-1:0] ptr_reg;
	// host pointer: load, or advance after each data access, wraps naturally
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ptr_reg <= {AW{1'b0}};
		else if (ptr_load)
			ptr_reg <= ptr_val;
		else if (host_wr || host_rd_adv)
			ptr_reg <= ptr_reg + {{(AW-1){1'b0}}, 1'b1};
	end
	// storage write: host port has priority over stream side
	always @(posedge pclk) begin
		if (host_wr)
			mem[ptr_reg] <= host_wdata;
		else if (strm_we)
			mem[strm_addr] <= strm_wdata;
	end
	assign ptr = ptr_reg;
	assign host_rdata = mem[ptr_reg];
	assign strm_rdata = mem[strm_addr];
endmodule
`default_nettype wire

// ### logic/psr_ring_stage.v
`timescale 1ns/1ns
`default_nettype none
`include "psr_regs.vh"
// one input-processor stop on the access ring
module psr_ring_stage #(
	parameter W = `PSR_RING_W,
	parameter SW = `PSR_SEL_W,
	parameter [SW-1:0] ID = 5'h00
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// ring
	input wire [W-1:0] ring_in,
	output wire [W-1:0] ring_out,
	// local access
	output wire hit
);
	reg [W-1:0] out_reg;
	wire sel_match;
	// select field sits just below the valid bit
	assign sel_match = ring_in[W-1] && (ring_in[W-2 -: SW] == ID);
	// addressed stop answers by inverting the 4-bit data field, rest of word kept; others pass unchanged
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			out_reg <= {W{1'b0}};
		else if (sel_match)
			out_reg <= {ring_in[W-1:4], ~ring_in[3:0]}; // R14
		else
			out_reg <= ring_in; // R14
	end
	assign ring_out = out_reg;
	assign hit = sel_match;
endmodule
`default_nettype wire

// ### logic/psr_top.v
// What this block does
// (R01) playback buffer is 256 entries of 16 bits
// (R02) host software packs playback samples; no packing here
// (R03) playback buffer loaded only through one shared data port
// (R04) each data-port write stores at pointer then increments pointer
// (R05) pointer register readable and writable by host
// (R06) start broadcast raises trigger and injects exactly 256 crossings
// (R07) injected data replaces stream right after input synchroniser
// (R08) spy captures main processor outputs into 256x16; input tap optional
// (R09) spy reached via one data and one pointer register
// (R10) bus supports only 16-bit data, 24-bit address accesses; the code reads the port register as 32 bits and uses write bits 17:16
// (R11) responding address range derived from geographic address
// (R12) decoded data word and sub-address forwarded to control side
// (R13) input processor accesses ride an 11-bit one-way ring
// (R14) ring stop acts when selected, else passes inputs on
// (R15) control end drives first ring segment, receives last
// (R16) daq and main processor reached via 16-bit two-way ports
// (R17) optional one-bit serial access port instead of ring
// (R18) optional 64-Mbit flash mapped into bus space; the code maps only 18 word-address bits (4 Mbit)
// (R19) broadcasts re-encoded onto eight processor signals
// (R20) spy data read returns word then increments, wrapping
// (R21) playback reads from zero, one word per crossing, then stops
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "psr_regs.vh"
module psr_top #(
	parameter NSTOP = 11,
	parameter GEO_W = 5
) (
	// apb slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	// geographic slot address
	input wire [GEO_W-1:0] geo_addr,
	// timing-link broadcast
	input wire bcast_strobe,
	input wire [7:0] bcast_cmd,
	output reg [7:0] proc_cmd,
	output reg capture_inject_trigger,
	output reg bunch_counter_clear,
	// real-time path
	input wire [15:0] sync_data,
	output reg [15:0] rt_data,
	input wire [15:0] main_out,
	input wire [15:0] inproc_out,
	// daq / main processor two-way ports
	input wire [15:0] daq_port_i,
	output reg [15:0] daq_port_o,
	output reg daq_port_oe,
	input wire [15:0] mp_port_i,
	output reg [15:0] mp_port_o,
	output reg mp_port_oe,
	// serial access alternative
	output reg ser_out,
	// flash window
	output reg [21:0] flash_addr,
	output reg flash_rd,
	input wire [15:0] flash_data
);
	localparam IDLE = 2'b00;
	localparam RUN = 2'b01;
	localparam W = `PSR_RING_W;

	// address decoding function used for every register select
	function is_reg;
		input [11:0] a;
		input [11:0] off;
		begin
			is_reg = (a == off);
		end
	endfunction

	wire [11:0] sub = paddr[11:0];
	// bus 24-bit space: slot from geo lines in bits 23:19, subset accepted only
	wire slot_hit = (paddr[23:19] == geo_addr) && (paddr[31:24] == 8'h00); // R11 R10
	wire acc = psel && penable;
	wire wr = acc && pwrite && slot_hit;
	wire rd = acc && !pwrite && slot_hit;
	wire flash_sel = paddr[18];
	wire known = flash_sel || is_reg(sub, `PSR_OFF_PB_DATA) || is_reg(sub, `PSR_OFF_PB_ADDR) ||
		is_reg(sub, `PSR_OFF_SPY_DATA) || is_reg(sub, `PSR_OFF_SPY_ADDR) ||
		is_reg(sub, `PSR_OFF_STATUS) || is_reg(sub, `PSR_OFF_CTRL) ||
		is_reg(sub, `PSR_OFF_RING) || is_reg(sub, `PSR_OFF_PORT) ||
		is_reg(sub, `PSR_OFF_GEO);
	assign pready = 1'b1;
	assign pslverr = acc && (!slot_hit || !known);

	// playback state
	reg [1:0] state_reg;
	reg [8:0] cnt_reg;
	reg [1:0] ctrl_reg;
	wire [7:0] pb_ptr, spy_ptr;
	wire [15:0] pb_rdata, spy_rdata, pb_strm;
	wire start = bcast_strobe && (bcast_cmd == `PSR_CMD_START);
	wire injecting = (state_reg == RUN);

	// playback buffer: host port writes and pointer, stream reads sequential
	psr_buf #(.AW(`PSR_AW), .DW(`PSR_DW)) u_pb (
		.pclk(pclk),
		.presetn(presetn),
		.ptr_load(wr && is_reg(sub, `PSR_OFF_PB_ADDR)), // R05
		.ptr_val(pwdata[7:0]),
		.host_wr(wr && !flash_sel && is_reg(sub, `PSR_OFF_PB_DATA)), // R03 R04 R01 R02
		.host_rd_adv(1'b0),
		.host_wdata(pwdata[15:0]),
		.ptr(pb_ptr),
		.host_rdata(pb_rdata),
		.strm_we(1'b0),
		.strm_addr(cnt_reg[7:0]), // R21
		.strm_wdata(16'h0000),
		.strm_rdata(pb_strm)
	);

	// spy buffer: captures during the same 256-crossing window
	psr_buf #(.AW(`PSR_AW), .DW(`PSR_DW)) u_spy (
		.pclk(pclk),
		.presetn(presetn),
		.ptr_load(wr && is_reg(sub, `PSR_OFF_SPY_ADDR)), // R09
		.ptr_val(pwdata[7:0]),
		.host_wr(1'b0),
		.host_rd_adv(rd && !flash_sel && is_reg(sub, `PSR_OFF_SPY_DATA)), // R20
		.host_wdata(16'h0000),
		.ptr(spy_ptr),
		.host_rdata(spy_rdata),
		.strm_we(injecting),
		.strm_addr(cnt_reg[7:0]),
		.strm_wdata(ctrl_reg[`PSR_CTRL_SPY_IN] ? inproc_out : main_out), // R08
		.strm_rdata()
	);

	// injection sequencer: 256 crossings from address zero then back to idle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= IDLE;
			cnt_reg <= 9'h000;
		end else begin
			case (state_reg)
				IDLE: begin
					cnt_reg <= 9'h000;
					if (start)
						state_reg <= RUN; // R06
				end
				RUN: begin
					if (cnt_reg == (`PSR_DEPTH - 1)) begin
						state_reg <= IDLE; // R21
						cnt_reg <= 9'h000;
					end else
						cnt_reg <= cnt_reg + 9'h001; // R06
				end
				default: state_reg <= IDLE;
			endcase
		end
	end

	// real-time mux after the synchroniser, plus broadcast re-encoding
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rt_data <= 16'h0000;
			capture_inject_trigger <= 1'b0;
			bunch_counter_clear <= 1'b0;
			proc_cmd <= 8'h00;
		end else begin
			rt_data <= injecting ? pb_strm : sync_data; // R07
			capture_inject_trigger <= start; // R06
			bunch_counter_clear <= bcast_strobe && (bcast_cmd == `PSR_CMD_BCR);
			proc_cmd <= {6'h00, bcast_strobe && (bcast_cmd == `PSR_CMD_BCR), start}; // R19
		end
	end

	// ring: control end launches word, stops pass it round, last returns here
	reg [W-1:0] ring_tx_reg;
	reg [W-1:0] ring_rx_reg;
	wire [W-1:0] seg [0:NSTOP];
	assign seg[0] = ring_tx_reg; // R15 R13
	genvar g;
	generate
		for (g = 0; g < NSTOP; g = g + 1) begin : g_stop
			psr_ring_stage #(.W(W), .SW(`PSR_SEL_W), .ID(g[4:0])) u_st (
				.pclk(pclk),
				.presetn(presetn),
				.ring_in(seg[g]),
				.ring_out(seg[g+1]),
				.hit()
			);
		end
	endgenerate

	// control, ring, port, serial and flash registers
	reg [15:0] ser_sh_reg;
	reg [4:0] ser_cnt_reg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= 2'b00;
			ring_tx_reg <= {W{1'b0}};
			ring_rx_reg <= {W{1'b0}};
			daq_port_o <= 16'h0000;
			daq_port_oe <= 1'b0;
			mp_port_o <= 16'h0000;
			mp_port_oe <= 1'b0;
			ser_sh_reg <= 16'h0000;
			ser_cnt_reg <= 5'h00;
			ser_out <= 1'b0;
			flash_addr <= 22'h000000;
			flash_rd <= 1'b0;
		end else begin
			if (seg[NSTOP][W-1])
				ring_rx_reg <= seg[NSTOP]; // R15
			if (wr && is_reg(sub, `PSR_OFF_CTRL))
				ctrl_reg <= pwdata[1:0];
			// ring word launched one cycle, serial path used when selected
			if (wr && is_reg(sub, `PSR_OFF_RING) && !ctrl_reg[`PSR_CTRL_SERIAL])
				ring_tx_reg <= pwdata[W-1:0]; // R13 R12
			else
				ring_tx_reg <= {W{1'b0}};
			if (wr && is_reg(sub, `PSR_OFF_RING) && ctrl_reg[`PSR_CTRL_SERIAL]) begin
				ser_sh_reg <= pwdata[15:0]; // R17
				ser_cnt_reg <= 5'h10;
			end else if (ser_cnt_reg != 5'h00) begin
				ser_out <= ser_sh_reg[15]; // R17
				ser_sh_reg <= {ser_sh_reg[14:0], 1'b0};
				ser_cnt_reg <= ser_cnt_reg - 5'h01;
			end else
				ser_out <= 1'b0;
			// port register: bit 16 selects main processor, bit 17 releases drive
			if (wr && is_reg(sub, `PSR_OFF_PORT)) begin
				if (pwdata[16]) begin
					mp_port_o <= pwdata[15:0]; // R16 R12
					mp_port_oe <= !pwdata[17];
				end else begin
					daq_port_o <= pwdata[15:0]; // R16 R12
					daq_port_oe <= !pwdata[17];
				end
			end
			flash_rd <= acc && slot_hit && flash_sel && !pwrite;
			if (acc && slot_hit && flash_sel)
				flash_addr <= paddr[21:0] & 22'h03ffff; // R18
		end
	end

	// read mux, 16-bit data in the low half; port register returns daq high, main processor low
	always @* begin
		prdata = `PSR_ZERO32;
		if (slot_hit) begin
			if (flash_sel)
				prdata = {16'h0000, flash_data}; // R18
			else if (is_reg(sub, `PSR_OFF_PB_DATA))
				prdata = {16'h0000, pb_rdata};
			else if (is_reg(sub, `PSR_OFF_PB_ADDR))
				prdata = {24'h000000, pb_ptr}; // R05
			else if (is_reg(sub, `PSR_OFF_SPY_DATA))
				prdata = {16'h0000, spy_rdata}; // R20 R09
			else if (is_reg(sub, `PSR_OFF_SPY_ADDR))
				prdata = {24'h000000, spy_ptr};
			else if (is_reg(sub, `PSR_OFF_STATUS))
				prdata = {22'h000000, injecting, cnt_reg};
			else if (is_reg(sub, `PSR_OFF_CTRL))
				prdata = {30'h00000000, ctrl_reg};
			else if (is_reg(sub, `PSR_OFF_RING))
				prdata = {21'h000000, ring_rx_reg};
			else if (is_reg(sub, `PSR_OFF_PORT))
				prdata = {daq_port_i, mp_port_i};
			else if (is_reg(sub, `PSR_OFF_GEO))
				prdata = {27'h0000000, geo_addr};
		end
	end
endmodule
`default_nettype wire

// ### test/psr_far_model.sv
`timescale 1ns/1ns
`default_nettype none
// processor fpgas beside the block: stream sources and the far ends of the two-way ports
module psr_far (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// stream and spy sources
	output logic [15:0] sync_data,
	output logic [15:0] main_out,
	output logic [15:0] inproc_out,
	output logic [15:0] flash_data,
	// two-way ports
	input wire [15:0] daq_port_o,
	input wire daq_port_oe,
	input wire [15:0] mp_port_o,
	input wire mp_port_oe,
	output logic [15:0] daq_port_i,
	output logic [15:0] mp_port_i
);
	logic [15:0] cnt;
	logic [15:0] dl;
	logic [15:0] ml;
	// counter makes every spy sample differ from its neighbour
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 16'h0000;
			dl <= 16'h0000;
			ml <= 16'h0000;
		end else begin
			cnt <= cnt + 16'h0001;
			if (daq_port_oe)
				dl <= ~daq_port_o;
			if (mp_port_oe)
				ml <= ~mp_port_o;
		end
	end
	// a released port shows the inverse of its last driven value
	assign sync_data = 16'hc3c3;
	assign main_out = cnt;
	assign inproc_out = ~cnt;
	assign flash_data = 16'h7e81;
	assign daq_port_i = daq_port_oe ? daq_port_o : dl;
	assign mp_port_i = mp_port_oe ? mp_port_o : ml;
endmodule
`default_nettype wire

// ### test/psr_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "psr_regs.vh"
// port-level checks on the slave and broadcast logic
module psr_chk #(
	parameter GEO_W = 5
) (
	// apb
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	// slot and broadcast
	input wire [GEO_W-1:0] geo_addr,
	input wire bcast_strobe,
	input wire [7:0] bcast_cmd,
	input wire [7:0] proc_cmd,
	input wire capture_inject_trigger,
	input wire bunch_counter_clear,
	// main processor port
	input wire [15:0] mp_port_o,
	input wire mp_port_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire st = bcast_strobe && bcast_cmd == `PSR_CMD_START;
	wire pw = acc && pwrite && !pslverr && paddr[11:0] == `PSR_OFF_PORT && !paddr[18];
	// broadcast decode
	a_trig_cause: assert property (capture_inject_trigger |-> $past(st))
		else $error("trigger without start");
	a_trig_single: assert property (capture_inject_trigger |=> !capture_inject_trigger)
		else $error("trigger longer than one cycle");
	a_clear_follows: assert property (bcast_strobe && bcast_cmd == `PSR_CMD_BCR
		|=> bunch_counter_clear && proc_cmd[1])
		else $error("clear not forwarded");
	a_start_code: assert property (proc_cmd[0] |-> $past(st))
		else $error("start code without start");
	// bus slave
	a_zero_wait: assert property (psel |-> pready)
		else $error("slave not ready");
	a_slot_refuse: assert property (acc && paddr[23:19] != geo_addr |-> pslverr)
		else $error("foreign slot accepted");
	a_upper_zero: assert property (acc && !pwrite && !pslverr
		&& paddr[11:0] != `PSR_OFF_PORT |-> prdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_port_drive: assert property (pw && pwdata[17:16] == 2'b01
		|=> mp_port_oe && mp_port_o == $past(pwdata[15:0]))
		else $error("main port not driven");
	c_start: cover property (capture_inject_trigger);
	c_clear: cover property (bunch_counter_clear);
	c_refuse: cover property (acc && pslverr);
endmodule
bind psr_top psr_chk #(.GEO_W(GEO_W)) u_psr_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .geo_addr(geo_addr),
	.bcast_strobe(bcast_strobe), .bcast_cmd(bcast_cmd), .proc_cmd(proc_cmd),
	.capture_inject_trigger(capture_inject_trigger),
	.bunch_counter_clear(bunch_counter_clear), .mp_port_o(mp_port_o), .mp_port_oe(mp_port_oe));
`default_nettype wire

// ### test/psr_top_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "psr_regs.vh"
module psr_top_test;
	localparam logic [31:0] B = 32'h0018_0000;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, bcast_strobe, se, rdy;
	logic [31:0] paddr, pwdata, q;
	logic [15:0] p;
	logic [7:0] bcast_cmd;
	wire [31:0] prdata;
	wire pready, pslverr, capture_inject_trigger, bunch_counter_clear, ser_out, flash_rd;
	wire daq_port_oe, mp_port_oe;
	wire [7:0] proc_cmd;
	wire [15:0] sync_data, rt_data, main_out, inproc_out, flash_data;
	wire [15:0] daq_port_i, daq_port_o, mp_port_i, mp_port_o;
	wire [21:0] flash_addr;
	int fail_count = 0;
	int comparisons = 0;
	int i, k;
	// clock
	initial begin
		forever #5 pclk = ~pclk;
	end
	psr_top u_psr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .geo_addr(5'h03), .bcast_strobe(bcast_strobe),
		.bcast_cmd(bcast_cmd), .proc_cmd(proc_cmd),
		.capture_inject_trigger(capture_inject_trigger),
		.bunch_counter_clear(bunch_counter_clear), .sync_data(sync_data), .rt_data(rt_data),
		.main_out(main_out), .inproc_out(inproc_out), .daq_port_i(daq_port_i),
		.daq_port_o(daq_port_o), .daq_port_oe(daq_port_oe), .mp_port_i(mp_port_i),
		.mp_port_o(mp_port_o), .mp_port_oe(mp_port_oe), .ser_out(ser_out),
		.flash_addr(flash_addr), .flash_rd(flash_rd), .flash_data(flash_data));
	psr_far u_psr_far (.pclk(pclk), .presetn(presetn), .sync_data(sync_data),
		.main_out(main_out), .inproc_out(inproc_out), .flash_data(flash_data),
		.daq_port_o(daq_port_o), .daq_port_oe(daq_port_oe), .mp_port_o(mp_port_o),
		.mp_port_oe(mp_port_oe), .daq_port_i(daq_port_i), .mp_port_i(mp_port_i));
	task automatic close_out;
		$display("mismatches %0d compares %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one apb transfer; read data and error taken at the edge that samples pready high
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			q = prdata;
			se = pslverr;
			rdy = pready;
			n++;
		end while (rdy !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] o, input logic [31:0] e);
		xfer(1'b0, B | o, 32'h0);
		chk(q, e);
	endtask
	task automatic bc(input logic [7:0] c);
		bcast_strobe <= 1'b1;
		bcast_cmd <= c;
		@(posedge pclk);
		bcast_strobe <= 1'b0;
		@(negedge pclk);
	endtask
	// test sequence
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, bcast_strobe} = 4'h0;
		{paddr, pwdata} = 64'h0;
		bcast_cmd = 8'h00;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b1, B | `PSR_OFF_PB_ADDR, 32'h0);
		for (i = 0; i < 256; i++)
			xfer(1'b1, B | `PSR_OFF_PB_DATA, 32'ha500 + i);
		rd(`PSR_OFF_PB_ADDR, 32'h0);
		xfer(1'b1, B | `PSR_OFF_PB_ADDR, 32'h5);
		rd(`PSR_OFF_PB_ADDR, 32'h5);
		rd(`PSR_OFF_PB_DATA, 32'ha505);
		@(negedge pclk);
		chk(rt_data, 16'hc3c3);
		@(posedge pclk);
		bc(`PSR_CMD_START);
		chk(capture_inject_trigger, 1'b1);
		chk(proc_cmd[0], 1'b1);
		k = 0;
		for (i = 0; i < 300; i++) begin
			@(negedge pclk);
			if (rt_data !== 16'hc3c3) begin
				chk(rt_data, 32'ha500 + k);
				k++;
			end
		end
		chk(k, 256);
		@(posedge pclk);
		xfer(1'b1, B | `PSR_OFF_SPY_ADDR, 32'h0);
		xfer(1'b0, B | `PSR_OFF_SPY_DATA, 32'h0);
		p = q[15:0];
		for (i = 1; i < 256; i++) begin
			xfer(1'b0, B | `PSR_OFF_SPY_DATA, 32'h0);
			chk(q, {16'h0, p + 16'h1});
			p = q[15:0];
		end
		rd(`PSR_OFF_SPY_ADDR, 32'h0);
		rd(`PSR_OFF_GEO, 32'h3);
		chk(se, 1'b0);
		xfer(1'b0, 32'h0020_0000, 32'h0);
		chk(se, 1'b1);
		xfer(1'b0, 32'h0118_0000, 32'h0);
		chk(se, 1'b1);
		xfer(1'b0, B | 12'h030, 32'h0);
		chk(se, 1'b1);
		xfer(1'b1, B | `PSR_OFF_RING, 32'h465);
		repeat (20) @(posedge pclk);
		rd(`PSR_OFF_RING, 32'h46a);
		xfer(1'b1, B | `PSR_OFF_RING, 32'h7e5);
		repeat (20) @(posedge pclk);
		rd(`PSR_OFF_RING, 32'h7e5);
		xfer(1'b1, B | `PSR_OFF_PORT, 32'h0001_1234);
		xfer(1'b1, B | `PSR_OFF_PORT, 32'h0000_abcd);
		chk({mp_port_oe, daq_port_oe, mp_port_o}, 18'h3_1234);
		chk(daq_port_o, 16'habcd);
		rd(`PSR_OFF_PORT, 32'habcd_1234);
		xfer(1'b1, B | `PSR_OFF_PORT, 32'h0002_0000);
		chk(daq_port_oe, 1'b0);
		bc(`PSR_CMD_BCR);
		chk({bunch_counter_clear, proc_cmd[1]}, 2'b11);
		rd(`PSR_OFF_STATUS, 32'h0);
		xfer(1'b0, B | 32'h0004_0123, 32'h0);
		chk(q, 32'h7e81);
		chk(flash_addr, 22'h000123);
		xfer(1'b1, B | `PSR_OFF_CTRL, 32'h1);
		rd(`PSR_OFF_CTRL, 32'h1);
		xfer(1'b1, B | `PSR_OFF_RING, 32'hb2c5);
		p = 16'h0;
		for (i = 0; i < 16; i++) begin
			@(negedge pclk);
			p = {p[14:0], ser_out};
		end
		chk(p, 16'hb2c5);
		close_out();
	end
endmodule
`default_nettype wire
